//--- shared/pmc_pkg.sv
// Package for the power mode controller: offsets, fields, states
package pmc_pkg;
  // Register byte offsets
  localparam logic [3:0] PMC_OFF_CTRL = 4'h0;
  localparam logic [3:0] PMC_OFF_STS = 4'h4;
  localparam logic [3:0] PMC_OFF_DBG = 4'h8;
  // Control register fields
  localparam int PMC_B_VREG = 0;
  localparam int PMC_B_DEPTH = 1;
  localparam int PMC_B_CLRW = 2;
  localparam int PMC_B_CLRS = 3;
  localparam int PMC_B_MEN = 4;
  localparam int PMC_B_SEL = 5;
  localparam int PMC_B_WPEN = 8;
  // Status register fields
  localparam int PMC_B_WEF = 0;
  localparam int PMC_B_SEF = 1;
  localparam int PMC_B_BELOW = 2;
  localparam int PMC_B_MODE = 4;
  // Debug register fields
  localparam int PMC_B_DBG_DS = 0;
  localparam int PMC_B_DBG_SB = 1;
  localparam logic [31:0] PMC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PMC_RDATA_ZERO = 32'h0000_0000;
  localparam logic [2:0] PMC_SEL_UNUSED = 3'h0;
  // Timing
  localparam int PMC_CLK_MHZ = 100;
  localparam int PMC_OSC_NS = 2000;
  localparam int PMC_REG_NS = 5000;
  localparam int PMC_OSC_CYC = (PMC_OSC_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam int PMC_REG_CYC = (PMC_REG_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam int PMC_CNT_W = 16;

  typedef enum logic [2:0] {
    PMC_RUN, PMC_SLEEP, PMC_DEEP, PMC_OSC_WAIT, PMC_REG_WAIT, PMC_STANDBY
  } pmc_state_t;

  // Core sleep request bundle
  typedef struct packed {
    logic wait_for_interrupt_instr;
    logic wait_for_event_instr;
    logic deep;
    logic after_exit;
    logic handler_ret;
  } pmc_core_req_t;

  // Standby wake sources
  typedef struct packed {
    logic ext_reset;
    logic watchdog;
    logic rtc_periodic;
    logic rtc_stamp;
    logic rtc_tamper;
    logic wakeup_pin;
    logic rtc_alarm;
  } pmc_sb_wake_t;

  // Power domain controls
  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic int_osc_en;
    logic ext_osc_en;
    logic pll_en;
    logic reg_on;
    logic reg_lp;
    logic core_pwr_on;
    logic core_reset_b;
    logic io_hiz;
    logic sysclk_int_osc;
    logic debug_alive;
  } pmc_pwr_t;
endpackage

//--- logic/pmc_top.sv
// Power mode controller with supply monitor and Avalon-MM registers
//
// What this block does
// - Monitor runs when enabled with nonzero select, outside standby, 3-bit threshold
// - Below-threshold flag shows comparison result
// - Upward crossing pulses external interrupt line 16
// - No deep, no exit-bit: sleep on instruction
// - Exit-bit set: sleep on handler return
// - Sleep stops only processor clock
// - Interrupt-entered sleep wakes on peripheral interrupt
// - Event-entered sleep wakes on any event
// - Events: pending-as-event interrupt or event line
// - Regulator select: zero normal, one low power
// - Deep sleep stops core clocks, fast oscillators
// - Interrupt-entered deep sleep wakes on interrupt line
// - Event-entered deep sleep wakes on event line
// - Deep exit: enable internal oscillator, then select
// - Low-power regulator adds extra wake delay
// - Standby powers off regulator, core, oscillators
// - Standby puts pins in high impedance
// - Standby exits on listed reset or wake sources
// - Debug drops in deep modes unless kept
// - Depth select: zero deep sleep, one standby
// - Standby-entered flag set, cleared by write one
// - Wakeup flag set, cleared by write one
`timescale 1ns/100ps
module pmc_top #(
  parameter int OSC_CYC = pmc_pkg::PMC_OSC_CYC,
  parameter int REG_CYC = pmc_pkg::PMC_REG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Processor core
  input wire pmc_pkg::pmc_core_req_t core_req,
  input wire logic periph_irq,
  input wire logic pend_event,
  input wire logic [15:0] ext_line_irq,
  input wire logic [15:0] ext_line_evt,
  // Analog and oscillator status
  input wire logic [7:0] supply_code,
  input wire logic int_osc_ready,
  // Standby wake sources
  input wire pmc_pkg::pmc_sb_wake_t sb_wake,
  // Outputs
  output pmc_pkg::pmc_pwr_t pwr,
  output logic ext_line16_pulse,
  output logic core_wake,
  output logic [2:0] monitor_threshold_select
);
  import pmc_pkg::*;

  pmc_state_t state_q;
  logic [31:0] ctrl_q;
  logic [1:0] dbg_q;
  logic wef_q, sef_q, below_q, below_prev_q, entered_wfe_q;
  logic [PMC_CNT_W-1:0] cnt_q;
  logic [7:0] sup_s1_q, sup_s2_q, sup_s3_q;
  logic osc_s1_q, osc_s2_q;
  pmc_sb_wake_t sb_s1_q, sb_s2_q, sb_prev_q;
  logic [15:0] ext_irq_s1_q, ext_irq_s2_q, ext_evt_s1_q, ext_evt_s2_q;
  logic irq_s1_q, irq_s2_q, pev_s1_q, pev_s2_q;

  logic monitor_enable, low_power_depth_select, regulator_low_power_select;
  logic sleep_req, wake_evt, sb_exit, sb_wakeup_event, wr_ctrl;
  logic [7:0] thr_code;

  // Threshold code for each select value
  function automatic logic [7:0] thr_of(input logic [2:0] sel);
    thr_of = {2'h0, sel, 3'h0} + 8'h70;
  endfunction

  assign monitor_enable = ctrl_q[PMC_B_MEN];
  assign low_power_depth_select = ctrl_q[PMC_B_DEPTH];
  assign regulator_low_power_select = ctrl_q[PMC_B_VREG];
  assign thr_code = thr_of(ctrl_q[PMC_B_SEL +: 3]);
  assign wr_ctrl = avs_write && avs_address == PMC_OFF_CTRL;

  // Input synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_s1_q <= 8'h00;
      sup_s2_q <= 8'h00;
      sup_s3_q <= 8'h00;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      sb_s1_q <= '0;
      sb_s2_q <= '0;
      sb_prev_q <= '0;
      ext_irq_s1_q <= 16'h0000;
      ext_irq_s2_q <= 16'h0000;
      ext_evt_s1_q <= 16'h0000;
      ext_evt_s2_q <= 16'h0000;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      pev_s1_q <= 1'b0;
      pev_s2_q <= 1'b0;
    end else begin
      sup_s1_q <= supply_code;
      sup_s2_q <= sup_s1_q;
      sup_s3_q <= sup_s2_q;
      osc_s1_q <= int_osc_ready;
      osc_s2_q <= osc_s1_q;
      sb_s1_q <= sb_wake;
      sb_s2_q <= sb_s1_q;
      sb_prev_q <= sb_s2_q;
      ext_irq_s1_q <= ext_line_irq;
      ext_irq_s2_q <= ext_irq_s1_q;
      ext_evt_s1_q <= ext_line_evt;
      ext_evt_s2_q <= ext_evt_s1_q;
      irq_s1_q <= periph_irq;
      irq_s2_q <= irq_s1_q;
      pev_s1_q <= pend_event;
      pev_s2_q <= pev_s1_q;
    end
  end

  // Wake decoding
  assign wake_evt = pev_s2_q || (|ext_evt_s2_q);
  assign sb_wakeup_event = (sb_s2_q.wakeup_pin && !sb_prev_q.wakeup_pin) ||
    (sb_s2_q.rtc_alarm && !sb_prev_q.rtc_alarm) || sb_s2_q.rtc_periodic ||
    sb_s2_q.rtc_stamp || sb_s2_q.rtc_tamper;
  assign sb_exit = sb_wakeup_event || sb_s2_q.ext_reset ||
    sb_s2_q.watchdog;
  assign sleep_req = core_req.after_exit ? core_req.handler_ret
    : (core_req.wait_for_interrupt_instr || core_req.wait_for_event_instr);

  // Control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= PMC_CTRL_RST;
    end else if (state_q == PMC_STANDBY && sb_exit) begin
      ctrl_q <= PMC_CTRL_RST;
    end else if (wr_ctrl && !avs_waitrequest) begin
      ctrl_q <= {23'h0, avs_writedata[PMC_B_WPEN:PMC_B_MEN], 2'h0,
        avs_writedata[PMC_B_DEPTH:PMC_B_VREG]};
    end
  end

  // Debug keep-alive register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dbg_q <= 2'h0;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == PMC_OFF_DBG) begin
      dbg_q <= avs_writedata[1:0];
    end
  end

  // Supply monitor
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      below_q <= 1'b0;
      below_prev_q <= 1'b0;
      ext_line16_pulse <= 1'b0;
      monitor_threshold_select <= 3'h0;
    end else begin
      monitor_threshold_select <= ctrl_q[PMC_B_SEL +: 3];
      if (monitor_enable && ctrl_q[PMC_B_SEL +: 3] != PMC_SEL_UNUSED &&
          state_q != PMC_STANDBY && sup_s2_q == sup_s3_q) begin
        below_q <= sup_s2_q < thr_code;
      end
      below_prev_q <= below_q;
      ext_line16_pulse <= below_prev_q && !below_q && monitor_enable;
    end
  end

  // Standby flags, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wef_q <= 1'b0;
      sef_q <= 1'b0;
    end else begin
      if (state_q == PMC_STANDBY && sb_wakeup_event) begin
        wef_q <= 1'b1;
      end else if (wr_ctrl && !avs_waitrequest &&
                   avs_writedata[PMC_B_CLRW]) begin
        wef_q <= 1'b0;
      end
      if (state_q == PMC_DEEP && low_power_depth_select) begin
        sef_q <= 1'b1;
      end else if (wr_ctrl && !avs_waitrequest &&
                   avs_writedata[PMC_B_CLRS]) begin
        sef_q <= 1'b0;
      end
    end
  end

  // Mode sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PMC_RUN;
      entered_wfe_q <= 1'b0;
      cnt_q <= '0;
      core_wake <= 1'b0;
    end else begin
      core_wake <= 1'b0;
      case (state_q)
        PMC_RUN: begin
          cnt_q <= '0;
          if (sleep_req) begin
            entered_wfe_q <= core_req.wait_for_event_instr;
            state_q <= core_req.deep ? PMC_DEEP : PMC_SLEEP;
          end
        end
        PMC_SLEEP: begin
          if (entered_wfe_q ? wake_evt : irq_s2_q) begin
            state_q <= PMC_RUN;
            core_wake <= 1'b1;
          end
        end
        PMC_DEEP: begin
          if (low_power_depth_select) begin
            state_q <= PMC_STANDBY;
          end else if (entered_wfe_q ? (|ext_evt_s2_q)
                       : (|ext_irq_s2_q)) begin
            state_q <= PMC_OSC_WAIT;
          end
        end
        PMC_OSC_WAIT: begin
          if (osc_s2_q && 32'(cnt_q) >= OSC_CYC - 1) begin
            cnt_q <= '0;
            if (regulator_low_power_select) begin
              state_q <= PMC_REG_WAIT;
            end else begin
              state_q <= PMC_RUN;
              core_wake <= 1'b1;
            end
          end else if (32'(cnt_q) < OSC_CYC) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PMC_REG_WAIT: begin
          if (32'(cnt_q) >= REG_CYC - 1) begin
            state_q <= PMC_RUN;
            core_wake <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PMC_STANDBY: begin
          if (sb_exit) begin
            state_q <= PMC_RUN;
            core_wake <= 1'b1;
          end
        end
        default: state_q <= PMC_RUN;
      endcase
    end
  end

  // Power domain outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr <= '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, int_osc_en: 1'b1,
        ext_osc_en: 1'b1, pll_en: 1'b1, reg_on: 1'b1, reg_lp: 1'b0,
        core_pwr_on: 1'b1, core_reset_b: 1'b0, io_hiz: 1'b0,
        sysclk_int_osc: 1'b1, debug_alive: 1'b1};
    end else begin
      pwr.cpu_clk_en <= state_q == PMC_RUN;
      pwr.core_clk_en <= state_q == PMC_RUN || state_q == PMC_SLEEP;
      pwr.int_osc_en <= state_q != PMC_DEEP && state_q != PMC_STANDBY;
      pwr.ext_osc_en <= state_q == PMC_RUN || state_q == PMC_SLEEP;
      pwr.pll_en <= state_q == PMC_RUN || state_q == PMC_SLEEP;
      pwr.reg_on <= state_q != PMC_STANDBY;
      pwr.reg_lp <= state_q == PMC_DEEP && regulator_low_power_select;
      pwr.core_pwr_on <= state_q != PMC_STANDBY;
      pwr.core_reset_b <= !(state_q == PMC_STANDBY);
      pwr.io_hiz <= state_q == PMC_STANDBY;
      if (state_q == PMC_DEEP && !low_power_depth_select) begin
        pwr.sysclk_int_osc <= 1'b0;
      end else if ((state_q == PMC_OSC_WAIT && osc_s2_q) ||
                   state_q == PMC_STANDBY) begin
        pwr.sysclk_int_osc <= 1'b1;
      end
      pwr.debug_alive <= (state_q == PMC_RUN || state_q == PMC_SLEEP) ||
        (state_q == PMC_STANDBY ? dbg_q[PMC_B_DBG_SB]
         : dbg_q[PMC_B_DBG_DS]);
    end
  end

  // Avalon slave: one wait cycle on every access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= PMC_RDATA_ZERO;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          PMC_OFF_CTRL: avs_readdata <= {ctrl_q[31:4], 2'h0,
            ctrl_q[PMC_B_DEPTH:PMC_B_VREG]};
          PMC_OFF_STS: avs_readdata <= {25'h0, state_q, 1'b0, below_q,
            sef_q, wef_q};
          PMC_OFF_DBG: avs_readdata <= {30'h0, dbg_q};
          default: avs_readdata <= PMC_RDATA_ZERO;
        endcase
      end
    end
  end
endmodule // pmc_top

//--- dv/pmc_core_model.sv
// Processor core model driving sleep requests and wake sources
`timescale 1ns/100ps
module pmc_core_model (
  // Clock
  input wire logic clk,
  // Requests and wake sources
  output pmc_pkg::pmc_core_req_t core_req,
  output logic periph_irq,
  output logic pend_event,
  output logic [15:0] ext_line_irq,
  output logic [15:0] ext_line_evt
);
  import pmc_pkg::*;
  initial begin
    core_req = 5'h00;
    periph_irq = 1'b0;
    pend_event = 1'b0;
    ext_line_irq = 16'h0000;
    ext_line_evt = 16'h0000;
  end
  // Levels with a one-cycle instruction pulse
  task automatic sleep_cmd(input logic evt, input logic dp, input logic ax);
    @(posedge clk);
    core_req <= {!evt && !ax, evt && !ax, dp, ax, ax};
    @(posedge clk);
    core_req <= {2'b00, dp, ax, 1'b0};
  endtask
  // Raise a wake source, or drop it as software would
  task automatic wake_src(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: periph_irq <= v;
      1: pend_event <= v;
      2: ext_line_irq <= {7'h00, v, 8'h00};
      default: ext_line_evt <= {13'h0, v, 2'h0};
    endcase
  endtask
endmodule // pmc_core_model

//--- dv/pmc_top_asserts.sv
// Checker for the power mode controller ports
`timescale 1ns/100ps
module pmc_top_asserts #(
  parameter int OSC_CYC = pmc_pkg::PMC_OSC_CYC,
  parameter int REG_CYC = pmc_pkg::PMC_REG_CYC
) (
  // Clock and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Core and outputs
  input wire pmc_pkg::pmc_core_req_t core_req,
  input wire pmc_pkg::pmc_pwr_t pwr,
  input wire logic ext_line16_pulse,
  input wire logic core_wake,
  input wire logic [2:0] monitor_threshold_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_bus;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_now;
    core_req.wait_for_interrupt_instr && !core_req.deep && !core_req.after_exit
      && pwr.cpu_clk_en |-> ##[1:2] !pwr.cpu_clk_en;
  endproperty
  a_now: assert property (p_now) else $error("no sleep on wfi");
  property p_exit;
    core_req.handler_ret && core_req.after_exit && !core_req.deep
      && pwr.cpu_clk_en |-> ##[1:2] !pwr.cpu_clk_en;
  endproperty
  a_exit: assert property (p_exit) else $error("no sleep on exit");
  property p_keep;
    !pwr.cpu_clk_en && pwr.core_clk_en |->
      pwr.reg_on && pwr.int_osc_en && !pwr.io_hiz;
  endproperty
  a_keep: assert property (p_keep) else $error("sleep domain off");
  property p_deep;
    !pwr.core_clk_en && pwr.core_pwr_on |->
      !pwr.ext_osc_en && !pwr.pll_en && !pwr.cpu_clk_en;
  endproperty
  a_deep: assert property (p_deep) else $error("deep clocks on");
  property p_lp;
    pwr.reg_lp |-> !pwr.core_clk_en && pwr.reg_on;
  endproperty
  a_lp: assert property (p_lp) else $error("reg lp in run");
  property p_sb;
    pwr.io_hiz |-> !pwr.reg_on && !pwr.core_pwr_on && !pwr.pll_en
      && !pwr.int_osc_en && !pwr.ext_osc_en;
  endproperty
  a_sb: assert property (p_sb) else $error("standby power on");
  property p_l16;
    ext_line16_pulse |-> monitor_threshold_select != 3'h0 ##1
      !ext_line16_pulse;
  endproperty
  a_l16: assert property (p_l16) else $error("bad line16 pulse");
  property p_osc;
    $rose(pwr.int_osc_en) && $past(pwr.core_pwr_on) |->
      !pwr.cpu_clk_en [*3];
  endproperty
  a_osc: assert property (p_osc) else $error("osc not first");
  property p_wake;
    $rose(pwr.cpu_clk_en) |-> $past(core_wake);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");
endmodule // pmc_top_asserts
bind pmc_top pmc_top_asserts #(.OSC_CYC(OSC_CYC), .REG_CYC(REG_CYC))
  u_asserts (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
  .core_req, .pwr, .ext_line16_pulse, .core_wake, .monitor_threshold_select);

//--- dv/pmc_top_tb.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/100ps
module pmc_top_tb;
  import pmc_pkg::*;
  localparam int REG = 12;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, int_osc_ready;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] supply_code;
  logic periph_irq, pend_event, ext_line16_pulse, core_wake;
  logic [15:0] ext_line_irq, ext_line_evt;
  logic [2:0] monitor_threshold_select;
  pmc_core_req_t core_req;
  pmc_sb_wake_t sb_wake;
  pmc_pwr_t pwr;
  int err_total, total_checks, c;
  pmc_top #(.OSC_CYC(4), .REG_CYC(REG)) u_dut (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .core_req, .periph_irq, .pend_event, .ext_line_irq, .ext_line_evt,
    .supply_code, .int_osc_ready, .sb_wake, .pwr, .ext_line16_pulse,
    .core_wake, .monitor_threshold_select);
  pmc_core_model u_core (.clk, .core_req, .periph_irq, .pend_event,
    .ext_line_irq, .ext_line_evt);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      chk("waitrequest", 32'h0, 32'h1);
      close_out();
    end
  endtask
  task automatic wait_run(input int lim);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (core_wake !== 1'b1 && c < lim);
    if (c >= lim) begin
      chk("core_wake", 32'h1, 32'h0);
      close_out();
    end
  endtask
  task automatic t_regs();
    bus(1'b0, PMC_OFF_CTRL, 32'h0, rd);
    chk("ctrl rst", PMC_CTRL_RST, rd);
    bus(1'b0, PMC_OFF_STS, 32'h0, rd);
    chk("sts rst", 32'h0, rd);
    bus(1'b1, PMC_OFF_CTRL, 32'h1ed, rd);
    bus(1'b0, PMC_OFF_CTRL, 32'h0, rd);
    chk("ctrl rw", 32'h1e1, rd);
    chk("sel", 32'h7, {29'h0, monitor_threshold_select});
    bus(1'b1, 4'hc, 32'hffffffff, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, PMC_OFF_STS, 32'h7, rd);
    bus(1'b0, PMC_OFF_STS, 32'h0, rd);
    chk("sts ro", 32'h0, rd);
    bus(1'b1, PMC_OFF_CTRL, 32'h0, rd);
    $display("regs test done");
  endtask
  task automatic t_sleep();
    int src[4] = '{0, 1, 3, 0};
    for (int i = 0; i < 4; i++) begin
      u_core.sleep_cmd(i == 1 || i == 2, 1'b0, i == 3);
      repeat (2) @(negedge clk);
      chk("sleep pwr", 32'h0e, {27'h0, pwr.cpu_clk_en, pwr.core_clk_en,
        pwr.int_osc_en, pwr.reg_on, pwr.io_hiz});
      bus(1'b0, PMC_OFF_STS, 32'h0, rd);
      chk("sleep mode", 32'h10, rd & 32'h70);
      u_core.wake_src(src[i], 1'b1);
      wait_run(20);
      u_core.wake_src(src[i], 1'b0);
      bus(1'b0, PMC_OFF_STS, 32'h0, rd);
      chk("run mode", 32'h0, rd & 32'h70);
    end
    $display("sleep test done");
  endtask
  task automatic t_deep();
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, PMC_OFF_DBG, j, rd);
      bus(1'b1, PMC_OFF_CTRL, j ? 32'h0 : 32'h1, rd);
      int_osc_ready <= 1'b0;
      u_core.sleep_cmd(j == 1, 1'b1, 1'b0);
      repeat (2) @(negedge clk);
      chk("deep pwr", j ? 32'h03 : 32'h0a, {24'h0, pwr.cpu_clk_en,
        pwr.core_clk_en, pwr.int_osc_en, pwr.ext_osc_en, pwr.reg_lp,
        pwr.io_hiz, pwr.core_pwr_on, pwr.debug_alive});
      bus(1'b0, PMC_OFF_STS, 32'h0, rd);
      chk("deep mode", 32'h20, rd & 32'h70);
      u_core.wake_src(j ? 3 : 2, 1'b1);
      repeat (10) @(negedge clk);
      chk("osc wait", 32'h2, {29'h0, pwr.sysclk_int_osc, pwr.int_osc_en,
        pwr.cpu_clk_en});
      @(posedge clk);
      int_osc_ready <= 1'b1;
      wait_run(100);
      chk("reg delay", {31'h0, j == 0}, {31'h0, c >= REG});
      chk("sysclk", 32'h1, {31'h0, pwr.sysclk_int_osc});
      u_core.wake_src(j ? 3 : 2, 1'b0);
    end
    $display("deep test done");
  endtask
  task automatic t_standby();
    for (int b = 0; b < 7; b++) begin
      bus(1'b1, PMC_OFF_CTRL, 32'h6, rd);
      u_core.sleep_cmd(1'b1, 1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk("sb pwr", 32'h1, {25'h0, pwr.core_reset_b, pwr.reg_on,
        pwr.core_pwr_on, pwr.pll_en, pwr.int_osc_en, pwr.ext_osc_en,
        pwr.io_hiz});
      @(posedge clk);
      sb_wake <= 7'h01 << b;
      wait_run(60);
      @(posedge clk);
      sb_wake <= 7'h00;
      bus(1'b0, PMC_OFF_STS, 32'h0, rd);
      chk("sb flags", b < 5 ? 32'h3 : 32'h2, rd & 32'h77);
      bus(1'b0, PMC_OFF_CTRL, 32'h0, rd);
      chk("ctrl lost", 32'h0, rd);
      bus(1'b1, PMC_OFF_CTRL, 32'hc, rd);
      bus(1'b0, PMC_OFF_STS, 32'h0, rd);
      chk("flag clr", 32'h0, rd & 32'h3);
    end
    $display("standby test done");
  endtask
  task automatic t_monitor();
    bus(1'b1, PMC_OFF_CTRL, 32'h30, rd);
    supply_code <= 8'h70;
    repeat (4) @(negedge clk);
    bus(1'b0, PMC_OFF_STS, 32'h0, rd);
    chk("below", 32'h4, rd & 32'h4);
    @(posedge clk);
    supply_code <= 8'h80;
    for (int n = 0; n < 10 && ext_line16_pulse !== 1'b1; n++) @(negedge clk);
    chk("line16", 32'h1, {31'h0, ext_line16_pulse});
    bus(1'b1, PMC_OFF_CTRL, 32'h0, rd);
    supply_code <= 8'h10;
    repeat (4) @(negedge clk);
    bus(1'b0, PMC_OFF_STS, 32'h0, rd);
    chk("idle", 32'h0, rd & 32'h4);
    $display("monitor test done");
  endtask
  initial begin
    err_total = 0;
    total_checks = 0;
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    supply_code = 8'hff;
    int_osc_ready = 1'b1;
    sb_wake = 7'h00;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_sleep();
    t_deep();
    t_standby();
    t_monitor();
    close_out();
  end
endmodule // pmc_top_tb
